/* fepg_defs.svh */
`ifndef FEPG_DEFS_SVH
`define FEPG_DEFS_SVH

// Register offsets, as seen on the configuration port.
`define FEPG_ADDR_TERM       8'h34
`define FEPG_ADDR_POWER      8'h35
`define FEPG_ADDR_BUFFER     8'h36
`define FEPG_ADDR_CHGAIN     8'h39
`define FEPG_ADDR_ATTEN      8'h3B

// Reset values of every register.
`define FEPG_RST_TERM        16'h0000
`define FEPG_RST_POWER       16'h0000
`define FEPG_RST_BUFFER      16'h0000
`define FEPG_RST_CHGAIN      16'h0000
`define FEPG_RST_ATTEN       16'h0000

// Writable bits of each register; reserved bits store nothing and read zero.
`define FEPG_MASK_TERM       16'hF7FF
`define FEPG_MASK_POWER      16'hFCFF
`define FEPG_MASK_BUFFER     16'h001F
`define FEPG_MASK_CHGAIN     16'hFFFF
`define FEPG_MASK_ATTEN      16'h03FC

// Input termination register fields.
`define FEPG_TERM_RES_LSB    0
`define FEPG_TERM_RES_MSB    4
`define FEPG_TERM_IND_BIT    5
`define FEPG_TERM_PRE_LSB    6
`define FEPG_TERM_PRE_MSB    7
`define FEPG_TERM_GAIN_LSB   13
`define FEPG_TERM_GAIN_MSB   14
`define FEPG_TERM_INDCH_BIT  15

// Power control register fields.
`define FEPG_PWR_LOW_BIT     10
`define FEPG_PWR_MED_BIT     11
`define FEPG_PWR_ATTPGA_BIT  12
`define FEPG_PWR_LNA_BIT     13
`define FEPG_PWR_PART_BIT    14
`define FEPG_PWR_COMP_BIT    15

// Buffer feedback field.
`define FEPG_BUF_FB_LSB      0
`define FEPG_BUF_FB_MSB      4

// Attenuator and filter register fields.
`define FEPG_ATT_HPF_LSB     2
`define FEPG_ATT_HPF_MSB     3
`define FEPG_ATT_CODE_LSB    4
`define FEPG_ATT_CODE_MSB    6
`define FEPG_ATT_EN_BIT      7
`define FEPG_ATT_BUFON_BIT   8
`define FEPG_ATT_TEST_BIT    9

// Feedback resistor conductances in units of 1/18000 S (450, 900, 1800, 3600, 4500 ohm).
`define FEPG_G_R0            7'd40
`define FEPG_G_R1            7'd20
`define FEPG_G_R2            7'd10
`define FEPG_G_R3            7'd5
`define FEPG_G_R4            7'd4

// Amplifier loop factor (1 + half the gain) that divides the feedback resistance.
`define FEPG_LOOP_12DB       10'd3
`define FEPG_LOOP_18DB       10'd5
`define FEPG_LOOP_24DB       10'd9

// Resistor codes chosen by the preset termination decoder.
`define FEPG_PRE_12_50       5'b00000
`define FEPG_PRE_12_100      5'b00011
`define FEPG_PRE_12_200      5'b00110
`define FEPG_PRE_12_400      5'b01100
`define FEPG_PRE_18_50       5'b00111
`define FEPG_PRE_18_100      5'b01110
`define FEPG_PRE_18_200      5'b11100
`define FEPG_PRE_18_400      5'b11000
`define FEPG_PRE_24_50       5'b00001
`define FEPG_PRE_24_100      5'b00010
`define FEPG_PRE_24_200      5'b00100
`define FEPG_PRE_24_400      5'b01000

`endif

/* fepg_pkg.sv */
package fepg_pkg;

  // Receive chain power mode, one-hot.
  typedef enum logic [2:0] {
    FEPG_PWR_LOW_NOISE = 3'b001,
    FEPG_PWR_LOW       = 3'b010,
    FEPG_PWR_MEDIUM    = 3'b100
  } fepg_power_mode_t;

  // Amplifier gain codes.
  typedef enum logic [1:0] {
    FEPG_GAIN_18DB = 2'b00,
    FEPG_GAIN_24DB = 2'b01,
    FEPG_GAIN_12DB = 2'b10,
    FEPG_GAIN_RSVD = 2'b11
  } fepg_lna_gain_t;

  // One request on the configuration port.
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } fepg_bus_req_t;

  // Chain-wide control outputs.
  typedef struct packed {
    fepg_power_mode_t mode;
    logic             attenuator_gain_stage_off;
    logic             input_amplifier_off;
    logic             chain_partial_off;
    logic             chain_complete_off;
    logic             buffer_power_on;
    logic             gain_stage_test_route;
    logic [4:0]       buffer_feedback_select;
    logic [1:0]       amplifier_corner_select;
    logic             digital_atten_enable;
    logic [2:0]       digital_atten_code;
  } fepg_ctrl_t;

endpackage

/* fepg_term_decode.sv */
`timescale 1ns/1ns
`default_nettype none
`include "fepg_defs.svh"

module fepg_term_decode
  import fepg_pkg::*;
(
  // Settings of one channel.
  input  wire fepg_lna_gain_t gain,
  input  wire logic [4:0]     res_code,
  input  wire logic           ind_en,
  input  wire logic [1:0]     preset,
  // Resulting resistor enables and input admittance.
  output logic [4:0]          res_enable,
  output logic [9:0]          admittance
);

  // Preset choice mapped to a resistor combination for the present gain.
  function automatic logic [4:0] preset_map(input fepg_lna_gain_t g, input logic [1:0] p);
    logic [4:0] r;
    r = 5'h00;
    case (g)
      FEPG_GAIN_12DB: r = (p == 2'd0) ? `FEPG_PRE_12_50 : (p == 2'd1) ? `FEPG_PRE_12_100 :
                          (p == 2'd2) ? `FEPG_PRE_12_200 : `FEPG_PRE_12_400;
      FEPG_GAIN_18DB: r = (p == 2'd0) ? `FEPG_PRE_18_50 : (p == 2'd1) ? `FEPG_PRE_18_100 :
                          (p == 2'd2) ? `FEPG_PRE_18_200 : `FEPG_PRE_18_400;
      FEPG_GAIN_24DB: r = (p == 2'd0) ? `FEPG_PRE_24_50 : (p == 2'd1) ? `FEPG_PRE_24_100 :
                          (p == 2'd2) ? `FEPG_PRE_24_200 : `FEPG_PRE_24_400;
      default:        r = 5'h00;
    endcase
    return r;
  endfunction

  wire logic [6:0] cond_units;
  wire logic [9:0] loop_factor;

  // Individual code wins when enabled, otherwise the preset decoder chooses.
  assign res_enable = ind_en ? res_code : preset_map(gain, preset);

  // Parallel resistors add conductance; all-zero code leaves the input high impedance.
  assign cond_units = (res_enable[0] ? `FEPG_G_R0 : 7'd0) + (res_enable[1] ? `FEPG_G_R1 : 7'd0) +
                      (res_enable[2] ? `FEPG_G_R2 : 7'd0) + (res_enable[3] ? `FEPG_G_R3 : 7'd0) +
                      (res_enable[4] ? `FEPG_G_R4 : 7'd0);

  // The amplifier loop scales the admittance seen at the input.
  assign loop_factor = (gain == FEPG_GAIN_12DB) ? `FEPG_LOOP_12DB :
                       (gain == FEPG_GAIN_18DB) ? `FEPG_LOOP_18DB :
                       (gain == FEPG_GAIN_24DB) ? `FEPG_LOOP_24DB : 10'd0;
  assign admittance  = 10'(10'(cond_units) * loop_factor);

endmodule

`default_nettype wire

/* fepg_config_regs.sv */
// Function
// - Medium-power bit alone selects medium power mode; both bits or neither select low-noise mode.
// - Attenuator-and-gain-stage power-down bit turns those two stages off.
// - Amplifier power-down bit turns off only the input amplifier.
// - Partial power-down bit partially turns off amplifier, attenuator and gain stage.
// - Complete power-down turns all three fully off and overrides partial power-down.
// - Five-bit buffer field selects the buffer amplifier feedback resistors.
// - Eight two-bit channel gain fields: 00 18dB, 01 24dB, 10 12dB, 11 reserved.
// - Two-bit corner field selects 100, 50, 200 or 150 kHz high-pass corner.
// - Digital attenuation code N gives about N times 6 dB when enabled.
// - Digital attenuation enable switches attenuator from analog to stepped digital control.
// - Buffer power bit is active high; zero keeps buffer amplifier off.
// - Gain-stage test bit routes gain stage outputs to the test outputs.
// - Each termination bit enables one feedback resistor; zero code enables none.
// - Preset terminations choose resistor combinations through a gain-aware decoder.
// - Input impedance depends on termination code and gain; zero code is high impedance.
// - Individual-channel enable makes per-channel gain fields replace the common gain.
// - Low-power bit alone selects low power mode.
`timescale 1ns/1ns
`default_nettype none
`include "fepg_defs.svh"

module fepg_config_regs
  import fepg_pkg::*;
#(
  parameter int NUM_CH = 8
)
(
  // Clock and reset.
  input  wire logic                  clk,
  input  wire logic                  rstn,
  // Configuration port.
  input  wire fepg_bus_req_t         bus_req,
  output logic [15:0]                rdata,
  // Chain-wide controls.
  output fepg_ctrl_t                 ctrl,
  // Per-channel gain, resistor enables and input admittance.
  output logic [NUM_CH*2-1:0]        ch_gain,
  output logic [NUM_CH*5-1:0]        ch_term_enable,
  output logic [NUM_CH*10-1:0]       ch_admittance
);

  // Stored registers.
  logic [15:0] term_q;
  logic [15:0] power_q;
  logic [15:0] buffer_q;
  logic [15:0] chgain_q;
  logic [15:0] atten_q;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;

  // Registered outputs.
  fepg_ctrl_t                ctrl_q;
  fepg_ctrl_t                ctrl_d;
  logic [NUM_CH*2-1:0]       gain_q;
  logic [NUM_CH*2-1:0]       gain_d;
  logic [NUM_CH*5-1:0]       term_en_q;
  logic [NUM_CH*5-1:0]       term_en_d;
  logic [NUM_CH*10-1:0]      adm_q;
  logic [NUM_CH*10-1:0]      adm_d;

  // Address decode.
  wire logic hit_term;
  wire logic hit_power;
  wire logic hit_buffer;
  wire logic hit_chgain;
  wire logic hit_atten;

  assign hit_term   = (bus_req.addr == `FEPG_ADDR_TERM);
  assign hit_power  = (bus_req.addr == `FEPG_ADDR_POWER);
  assign hit_buffer = (bus_req.addr == `FEPG_ADDR_BUFFER);
  assign hit_chgain = (bus_req.addr == `FEPG_ADDR_CHGAIN);
  assign hit_atten  = (bus_req.addr == `FEPG_ADDR_ATTEN);

  // Register writes keep only the defined bits, so reserved bits stay zero.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      term_q   <= `FEPG_RST_TERM;
      power_q  <= `FEPG_RST_POWER;
      buffer_q <= `FEPG_RST_BUFFER;
      chgain_q <= `FEPG_RST_CHGAIN;
      atten_q  <= `FEPG_RST_ATTEN;
    end else if (bus_req.wr) begin
      if (hit_term)   term_q   <= bus_req.wdata & `FEPG_MASK_TERM;
      if (hit_power)  power_q  <= bus_req.wdata & `FEPG_MASK_POWER;
      if (hit_buffer) buffer_q <= bus_req.wdata & `FEPG_MASK_BUFFER;
      if (hit_chgain) chgain_q <= bus_req.wdata & `FEPG_MASK_CHGAIN;
      if (hit_atten)  atten_q  <= bus_req.wdata & `FEPG_MASK_ATTEN;
    end
  end

  // Read selection; unmapped addresses and idle cycles return zero.
  always_comb begin
    rdata_d = 16'h0000;
    if (bus_req.rd) begin
      if (hit_term)        rdata_d = term_q;
      else if (hit_power)  rdata_d = power_q;
      else if (hit_buffer) rdata_d = buffer_q;
      else if (hit_chgain) rdata_d = chgain_q;
      else if (hit_atten)  rdata_d = atten_q;
    end
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) rdata_q <= 16'h0000;
    else       rdata_q <= rdata_d;
  end

  // Power mode and power-down resolution.
  wire logic low_bit;
  wire logic med_bit;
  assign low_bit = power_q[`FEPG_PWR_LOW_BIT];
  assign med_bit = power_q[`FEPG_PWR_MED_BIT];

  // Chain-wide control decode.
  always_comb begin
    ctrl_d      = '0;
    ctrl_d.mode = FEPG_PWR_LOW_NOISE;
    if (med_bit && !low_bit) begin
      ctrl_d.mode = FEPG_PWR_MEDIUM;
    end else if (low_bit && !med_bit) begin
      ctrl_d.mode = FEPG_PWR_LOW;
    end
    ctrl_d.attenuator_gain_stage_off = power_q[`FEPG_PWR_ATTPGA_BIT];
    ctrl_d.input_amplifier_off       = power_q[`FEPG_PWR_LNA_BIT];
    ctrl_d.chain_complete_off        = power_q[`FEPG_PWR_COMP_BIT];
    ctrl_d.chain_partial_off         = power_q[`FEPG_PWR_PART_BIT] && !power_q[`FEPG_PWR_COMP_BIT];
    ctrl_d.buffer_feedback_select    = buffer_q[`FEPG_BUF_FB_MSB:`FEPG_BUF_FB_LSB];
    ctrl_d.amplifier_corner_select   = atten_q[`FEPG_ATT_HPF_MSB:`FEPG_ATT_HPF_LSB];
    ctrl_d.digital_atten_enable      = atten_q[`FEPG_ATT_EN_BIT];
    ctrl_d.digital_atten_code        = atten_q[`FEPG_ATT_EN_BIT] ?
                                       atten_q[`FEPG_ATT_CODE_MSB:`FEPG_ATT_CODE_LSB] : 3'h0;
    ctrl_d.buffer_power_on           = atten_q[`FEPG_ATT_BUFON_BIT];
    ctrl_d.gain_stage_test_route     = atten_q[`FEPG_ATT_TEST_BIT];
  end

  // Common gain and the individual-channel switch.
  wire fepg_lna_gain_t common_gain;
  wire logic           ind_ch;
  assign common_gain = fepg_lna_gain_t'(term_q[`FEPG_TERM_GAIN_MSB:`FEPG_TERM_GAIN_LSB]);
  assign ind_ch      = term_q[`FEPG_TERM_INDCH_BIT];

  // One gain resolver and termination decoder for each channel.
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    wire fepg_lna_gain_t eff_gain;
    // Channel i owns gain bits 2i+1:2i; channel one sits in the lowest pair.
    assign eff_gain = ind_ch ? fepg_lna_gain_t'(chgain_q[2*i+1 -: 2]) : common_gain;
    assign gain_d[2*i+1 -: 2] = eff_gain;
    fepg_term_decode u_dec (
      .gain       (eff_gain),
      .res_code   (term_q[`FEPG_TERM_RES_MSB:`FEPG_TERM_RES_LSB]),
      .ind_en     (term_q[`FEPG_TERM_IND_BIT]),
      .preset     (term_q[`FEPG_TERM_PRE_MSB:`FEPG_TERM_PRE_LSB]),
      .res_enable (term_en_d[5*i+4 -: 5]),
      .admittance (adm_d[10*i+9 -: 10])
    );
  end

  // All decoded outputs leave through flip-flops.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q    <= '{mode: FEPG_PWR_LOW_NOISE, default: '0};
      gain_q    <= '0;
      term_en_q <= '0;
      adm_q     <= '0;
    end else begin
      ctrl_q    <= ctrl_d;
      gain_q    <= gain_d;
      term_en_q <= term_en_d;
      adm_q     <= adm_d;
    end
  end

  assign rdata          = rdata_q;
  assign ctrl           = ctrl_q;
  assign ch_gain        = gain_q;
  assign ch_term_enable = term_en_q;
  assign ch_admittance  = adm_q;

  // Checks on the register bank and its decoded outputs.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // A write reaches the decoded outputs two edges later.
  property p_medium_mode;
    bus_req.wr && hit_power && bus_req.wdata[11] && !bus_req.wdata[10]
      |-> ##2 ctrl.mode == FEPG_PWR_MEDIUM;
  endproperty
  a_medium_mode: assert property (p_medium_mode) else $error("medium power mode not reached");

  property p_low_mode;
    bus_req.wr && hit_power && bus_req.wdata[10] && !bus_req.wdata[11]
      |-> ##2 ctrl.mode == FEPG_PWR_LOW;
  endproperty
  a_low_mode: assert property (p_low_mode) else $error("low power mode not reached");

  property p_noise_mode;
    power_q[11] == power_q[10] |=> ctrl.mode == FEPG_PWR_LOW_NOISE;
  endproperty
  a_noise_mode: assert property (p_noise_mode) else $error("low noise mode not kept");

  property p_att_pga_off;
    ##1 ctrl.attenuator_gain_stage_off == $past(power_q[12]);
  endproperty
  a_att_pga_off: assert property (p_att_pga_off) else $error("attenuator power-down mismatch");

  property p_lna_only;
    bus_req.wr && hit_power && bus_req.wdata[15:12] == 4'h2
      |-> ##2 ctrl.input_amplifier_off && !ctrl.attenuator_gain_stage_off && !ctrl.chain_partial_off
          && !ctrl.chain_complete_off;
  endproperty
  a_lna_only: assert property (p_lna_only) else $error("amplifier power-down not isolated");

  property p_complete_wins;
    ctrl.chain_complete_off |-> !ctrl.chain_partial_off;
  endproperty
  a_complete_wins: assert property (p_complete_wins) else $error("partial power-down beside complete");

  property p_partial;
    power_q[14] && !power_q[15] |=> ctrl.chain_partial_off;
  endproperty
  a_partial: assert property (p_partial) else $error("partial power-down missing");

  property p_buffer_fb;
    bus_req.wr && hit_buffer |-> ##2 ctrl.buffer_feedback_select == $past(bus_req.wdata[4:0], 2);
  endproperty
  a_buffer_fb: assert property (p_buffer_fb) else $error("buffer feedback select wrong");

  property p_chan1_gain;
    ind_ch |=> ch_gain[1:0] == $past(chgain_q[1:0]);
  endproperty
  a_chan1_gain: assert property (p_chan1_gain) else $error("channel one gain not from its field");

  property p_common_gain;
    !ind_ch |=> ch_gain[2*NUM_CH-1 -: 2] == $past(term_q[14:13]);
  endproperty
  a_common_gain: assert property (p_common_gain) else $error("common gain not applied");

  property p_corner;
    ##1 ctrl.amplifier_corner_select == $past(atten_q[3:2]);
  endproperty
  a_corner: assert property (p_corner) else $error("corner select mismatch");

  property p_atten_off;
    !atten_q[7] |=> ctrl.digital_atten_code == 3'h0 && !ctrl.digital_atten_enable;
  endproperty
  a_atten_off: assert property (p_atten_off) else $error("stepped attenuation while disabled");

  property p_buf_power;
    bus_req.wr && hit_atten |-> ##2 ctrl.buffer_power_on == $past(bus_req.wdata[8], 2)
      && ctrl.gain_stage_test_route == $past(bus_req.wdata[9], 2);
  endproperty
  a_buf_power: assert property (p_buf_power) else $error("buffer power or test route wrong");

  property p_high_z;
    term_q[5] && term_q[4:0] == 5'h00 |=> ch_admittance[9:0] == 10'h000 && ch_term_enable[4:0] == 5'h00;
  endproperty
  a_high_z: assert property (p_high_z) else $error("zero code not high impedance");

  property p_24db_450;
    term_q[5] && term_q[4:0] == 5'h01 && ch_gain[1:0] == 2'b01 && $stable(term_q) && $stable(chgain_q)
      |=> ch_admittance[9:0] == 10'd360;
  endproperty
  a_24db_450: assert property (p_24db_450) else $error("450 ohm at 24 dB not 50 ohm");

  property p_read;
    bus_req.rd && hit_power |=> rdata == $past(power_q) ##1 rdata == 16'h0000 || $past(bus_req.rd);
  endproperty
  a_read: assert property (p_read) else $error("read data not for one cycle");

  // Main scenarios worth seeing.
  c_medium:   cover property (ctrl.mode == FEPG_PWR_MEDIUM);
  c_complete: cover property (power_q[14] && ctrl.chain_complete_off);
  c_indiv:    cover property (ind_ch && ch_gain[15:14] == 2'b10);
  c_preset:   cover property (!term_q[5] && ch_term_enable[4:0] != 5'h00);

endmodule

`default_nettype wire

/* fepg_config_regs_bench.sv */
`timescale 1ns/1ns
`default_nettype none
`include "fepg_defs.svh"

// Counts one comparison and reports a mismatch at once.
`define FEPG_CHK(name, exp, got) \
  begin \
    cmp_count++; \
    if ((exp) !== (got)) begin \
      fail_count++; \
      $display("mismatch %s expected %0h seen %0h", name, exp, got); \
    end \
  end

module fepg_config_regs_bench
  import fepg_pkg::*;
;
  localparam int NUM_CH = 8;
  // Mapped addresses followed by one unmapped address.
  localparam logic [7:0] ADDRS [6] = '{8'h34, 8'h35, 8'h36, 8'h39, 8'h3B, 8'h37};

  logic                 clk;
  logic                 rstn;
  fepg_bus_req_t        bus_req;
  logic [15:0]          rdata;
  fepg_ctrl_t           ctrl;
  logic [NUM_CH*2-1:0]  ch_gain;
  logic [NUM_CH*5-1:0]  ch_term_enable;
  logic [NUM_CH*10-1:0] ch_admittance;
  logic [15:0]          shadow [256];
  logic [15:0]          lfsr_q;
  int                   fail_count;
  int                   cmp_count;

  // Device under test.
  fepg_config_regs #(.NUM_CH(NUM_CH)) fepg_config_regs_inst (
    .clk            (clk),
    .rstn           (rstn),
    .bus_req        (bus_req),
    .rdata          (rdata),
    .ctrl           (ctrl),
    .ch_gain        (ch_gain),
    .ch_term_enable (ch_term_enable),
    .ch_admittance  (ch_admittance)
  );

  // Next value of the stimulus shift register.
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Writable bits of each address; unmapped places keep nothing.
  function automatic logic [15:0] reg_mask(input logic [7:0] a);
    case (a)
      8'h34: return 16'hF7FF;
      8'h35: return 16'hFCFF;
      8'h36: return 16'h001F;
      8'h39: return 16'hFFFF;
      8'h3B: return 16'h03FC;
      default: return 16'h0000;
    endcase
  endfunction

  // Expected chain-wide controls from the shadow registers.
  function automatic fepg_ctrl_t exp_ctrl();
    fepg_ctrl_t c;
    logic [15:0] p;
    logic [15:0] t;
    p = shadow[8'h35];
    t = shadow[8'h3B];
    c.mode = (p[11] && !p[10]) ? FEPG_PWR_MEDIUM : (p[10] && !p[11]) ? FEPG_PWR_LOW : FEPG_PWR_LOW_NOISE;
    c.attenuator_gain_stage_off = p[12];
    c.input_amplifier_off = p[13];
    c.chain_partial_off = p[14] & ~p[15];
    c.chain_complete_off = p[15];
    c.buffer_power_on = t[8];
    c.gain_stage_test_route = t[9];
    c.buffer_feedback_select = shadow[8'h36][4:0];
    c.amplifier_corner_select = t[3:2];
    c.digital_atten_enable = t[7];
    c.digital_atten_code = t[7] ? t[6:4] : 3'h0;
    return c;
  endfunction

  // Effective gain of one channel: its own field or the common one.
  function automatic logic [1:0] exp_gain(input int ch);
    return shadow[8'h34][15] ? shadow[8'h39][2*ch +: 2] : shadow[8'h34][14:13];
  endfunction

  // Resistor enables: the individual code, or the preset mapped by gain.
  function automatic logic [4:0] exp_res(input logic [1:0] g);
    logic [15:0] t;
    t = shadow[8'h34];
    if (t[5]) return t[4:0];
    case ({g, t[7:6]})
      4'h0: return `FEPG_PRE_18_50;
      4'h1: return `FEPG_PRE_18_100;
      4'h2: return `FEPG_PRE_18_200;
      4'h3: return `FEPG_PRE_18_400;
      4'h4: return `FEPG_PRE_24_50;
      4'h5: return `FEPG_PRE_24_100;
      4'h6: return `FEPG_PRE_24_200;
      4'h7: return `FEPG_PRE_24_400;
      4'h8: return `FEPG_PRE_12_50;
      4'h9: return `FEPG_PRE_12_100;
      4'hA: return `FEPG_PRE_12_200;
      4'hB: return `FEPG_PRE_12_400;
      default: return 5'h00;
    endcase
  endfunction

  // Admittance in units of 1/18000 S: resistor conductances times the loop factor.
  function automatic logic [9:0] exp_adm(input logic [1:0] g, input logic [4:0] r);
    int k;
    k = 40 * r[0] + 20 * r[1] + 10 * r[2] + 5 * r[3] + 4 * r[4];
    case (g)
      2'b10: return 10'(k * 3);
      2'b00: return 10'(k * 5);
      2'b01: return 10'(k * 9);
      default: return 10'h000;
    endcase
  endfunction

  // Compares every decoded output with the expectation.
  task automatic check_outputs();
    logic [1:0] g;
    logic [4:0] r;
    `FEPG_CHK("ctrl", exp_ctrl(), ctrl)
    for (int ch = 0; ch < NUM_CH; ch++) begin
      g = exp_gain(ch);
      r = exp_res(g);
      `FEPG_CHK("ch_gain", g, ch_gain[2*ch +: 2])
      `FEPG_CHK("ch_term_enable", r, ch_term_enable[5*ch +: 5])
      `FEPG_CHK("ch_admittance", exp_adm(g, r), ch_admittance[10*ch +: 10])
    end
  endtask

  // One write cycle; the decoded outputs are checked two edges later.
  task automatic write_check(input logic [7:0] a, input logic [15:0] d);
    // The host keeps reserved bits at zero and never asks for both power modes at once.
    if (reg_mask(a) != 16'h0000) d = d & reg_mask(a);
    if (a == 8'h35 && d[11] && d[10]) d[10] = 1'b0;
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req <= '0;
    shadow[a] = d & reg_mask(a);
    @(posedge clk);
    #1;
    check_outputs();
  endtask

  // One read cycle; data stand for one cycle, then return to zero.
  task automatic read_check(input logic [7:0] a);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req <= '0;
    #1;
    `FEPG_CHK("rdata", shadow[a], rdata)
    @(posedge clk);
    #1;
    `FEPG_CHK("rdata_idle", 16'h0000, rdata)
  endtask

  // Prints the verdict and ends the run.
  task automatic give_verdict();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Free-running 50 MHz clock.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    give_verdict();
  end

  // Main sequence: reset values, power modes, termination sweep, random traffic, second reset.
  initial begin
    logic [7:0] a;
    rstn = 1'b0;
    bus_req = '0;
    fail_count = 0;
    cmp_count = 0;
    lfsr_q = 16'h0051;
    foreach (shadow[i]) shadow[i] = 16'h0000;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    // Decoded outputs follow the reset registers one edge after release.
    @(posedge clk);
    #1;
    check_outputs();
    foreach (ADDRS[i]) read_check(ADDRS[i]);
    // Every combination of power-down bits with each mode setting except both mode bits set, channel bits random.
    for (int k = 0; k < 64; k++) begin
      lfsr_q = lfsr_next(lfsr_q);
      write_check(8'h35, {k[3:0], k[5:4], 2'b11, lfsr_q[7:0]});
    end
    // Every gain with every individual code and every preset.
    for (int k = 0; k < 256; k++) begin
      write_check(8'h34, {1'b0, k[7:6], 5'h00, k[1:0], k[5], k[4:0]});
    end
    // All writable ones everywhere shows which bits are stored.
    foreach (ADDRS[i]) begin
      write_check(ADDRS[i], 16'hFFFF);
      read_check(ADDRS[i]);
    end
    // Random traffic over mapped and unmapped places.
    for (int n = 0; n < 150; n++) begin
      lfsr_q = lfsr_next(lfsr_q);
      a = ADDRS[lfsr_q % 6];
      lfsr_q = lfsr_next(lfsr_q);
      write_check(a, lfsr_q);
      read_check(a);
    end
    // A second reset in mid-run restores every default.
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    foreach (shadow[i]) shadow[i] = 16'h0000;
    rstn <= 1'b1;
    @(posedge clk);
    #1;
    check_outputs();
    foreach (ADDRS[i]) read_check(ADDRS[i]);
    give_verdict();
  end

endmodule

`default_nettype wire
